// File: rtl/dss_pkg.sv
package dss_pkg;
    // Setting encodings and scales
    localparam logic [1:0]  DSS_STOP_RAMP       = 2'h0;
    localparam logic [1:0]  DSS_STOP_COAST      = 2'h1;
    localparam logic [1:0]  DSS_STOP_DCBRAKE    = 2'h2;
    localparam logic [1:0]  DSS_STOP_COAST_TMR  = 2'h3;
    // Frequencies in 0.1 Hz units, times in 10 ms units, current in percent
    localparam int          DSS_FREQ_W          = 16;
    localparam int          DSS_TIME_W          = 16;
    localparam logic [15:0] DSS_BRK_FREQ_MAX    = 16'h0064; // 10.0 Hz
    localparam logic [15:0] DSS_BRK_FREQ_RST    = 16'h0005; // 0.5 Hz
    localparam logic [6:0]  DSS_BRK_CUR_MAX     = 7'h64;    // 100 % = rated current
    localparam logic [6:0]  DSS_BRK_CUR_RST     = 7'h32;    // 50 %
    localparam logic [9:0]  DSS_PCT_TO_PM       = 10'h00a;  // Percent to permille of rated current
    localparam logic [15:0] DSS_BRK_TIME_MAX    = 16'h03e8; // 10.00 s
    localparam logic [15:0] DSS_STOP_BRK_RST    = 16'h0032; // 0.50 s
    localparam logic [15:0] DSS_START_BRK_RST   = 16'h0000; // 0.00 s
    localparam logic [1:0]  DSS_METHOD_RST      = 2'h0;
    // One time unit is 10 ms
    localparam int          DSS_CLK_HZ          = 100000000;
    localparam int          DSS_TICK_MS         = 10;
    localparam int          DSS_TICK_CYC        = DSS_CLK_HZ / 1000 * DSS_TICK_MS;

    typedef enum logic [2:0] {
        DSS_ST_IDLE     = 3'b000,
        DSS_ST_START_DC = 3'b001,
        DSS_ST_RUN      = 3'b010,
        DSS_ST_RAMP     = 3'b011,
        DSS_ST_BASEBLK  = 3'b100,
        DSS_ST_STOP_DC  = 3'b101,
        DSS_ST_LOCKOUT  = 3'b110
    } dss_state_t;

    // Settings that travel together
    typedef struct packed {
        logic [1:0]  stop_method_select;
        logic [15:0] brake_start_frequency;
        logic [6:0]  brake_current_percent;
        logic [15:0] start_brake_duration;
        logic [15:0] stop_brake_duration;
    } dss_cfg_t;
endpackage

// File: rtl/dss_drive_stop_sequencer.sv
// Behaviour
// - The stop method is a two-bit setting, default 0, selecting ramp, coast, DC braking stop or coast with lockout.
// - Method 0 ramps the output frequency down to zero at the deceleration time when run is removed.
// - During a ramped stop, below the braking start frequency, DC is injected at the braking current for the stop duration.
// - Braking start frequency spans 0.0 to 10.0 Hz, default 0.5 Hz, and is raised to the minimum output frequency.
// - Braking current is a percentage 0 to 100, default 50, where 100 is rated current.
// - Stop braking duration spans 0.00 to 10.00 s, default 0.50 s, and zero suppresses stop injection.
// - Method 1 turns the output off at once so the motor coasts.
// - After a coast stop, run requests are ignored until the minimum output-off interval has elapsed.
// - Method 2 holds the output off for the minimum output-off interval, then injects DC.
// - Method 2 injection time scales the stop duration by the output frequency at the stop instant.
// - Method 3 coasts and ignores run requests for a lockout time from stop frequency and deceleration time.
// - Start braking injects DC for 0.00 to 10.00 s before acceleration, default zero, and zero skips it.
// - Deceleration time is the time to fall from maximum output frequency to zero.
`timescale 1ns/100ps
`default_nettype none
module dss_drive_stop_sequencer
    import dss_pkg::*;
#(
    parameter int TICK_CYC = DSS_TICK_CYC
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_run,
    input  wire dss_cfg_t              i_cfg,
    input  wire logic                  i_cfg_write,
    input  wire logic [DSS_FREQ_W-1:0] i_target_frequency,
    input  wire logic [DSS_FREQ_W-1:0] i_min_output_frequency,
    input  wire logic [DSS_FREQ_W-1:0] i_max_output_frequency,
    input  wire logic [DSS_TIME_W-1:0] i_decel_time_first,
    input  wire logic [DSS_TIME_W-1:0] i_min_output_off_interval,
    output logic [DSS_FREQ_W-1:0]      o_output_frequency,
    output logic                       o_output_enable,
    output logic                       o_dc_inject,
    output logic [9:0]                 o_dc_current_permille,
    output logic                       o_run_ignored,
    output logic [2:0]                 o_state,
    output dss_cfg_t                   o_cfg_active
);

    // Scale a time by f / fmax and clamp it back to a time-count width.
    // A zero fmax falls back to the unscaled time instead of dividing by zero.
    function automatic logic [DSS_TIME_W-1:0] dss_scale(input logic [DSS_TIME_W-1:0] t,
                                                       input logic [DSS_FREQ_W-1:0] f,
                                                       input logic [DSS_FREQ_W-1:0] fmax);
        logic [31:0] prod;
        logic [31:0] q;
        prod = 32'(t) * 32'(f);
        q    = (fmax == '0) ? 32'(t) : prod / 32'(fmax);
        dss_scale = (q > 32'h0000ffff) ? 16'hffff : q[15:0];
    endfunction

    // Saturate a setting at the top of its range
    function automatic logic [15:0] dss_clamp(input logic [15:0] v,
                                              input logic [15:0] vmax);
        dss_clamp = (v > vmax) ? vmax : v;
    endfunction

    // Sequencer, timer and output registers
    dss_state_t              state_reg, state_next;
    dss_cfg_t                cfg_reg;
    logic [31:0]             tick_cnt_reg;
    logic                    tick;
    logic [DSS_TIME_W-1:0]   timer_reg, timer_next;
    logic [DSS_FREQ_W-1:0]   freq_reg, freq_next;
    logic [DSS_FREQ_W-1:0]   stop_freq_reg;
    logic [31:0]             ramp_acc_reg, ramp_acc_next;
    logic                    run_ignored_reg;
    logic                    inject_reg;
    logic [9:0]              current_reg;

    // Tick every time unit; one divider keeps all time settings in one unit.
    // The divider free-runs, so a timed span may start up to one tick early;
    // the settings are coarse enough that this phase error does not matter.
    assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_reg <= 32'h0;
        end else if (tick) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    // Setting limits, applied on acceptance; an out-of-range value saturates at
    // the top of its range rather than wrapping
    wire logic [15:0] brk_freq_lim  = dss_clamp(i_cfg.brake_start_frequency, DSS_BRK_FREQ_MAX);
    wire logic [6:0]  brk_cur_lim   = 7'(dss_clamp(16'(i_cfg.brake_current_percent), 16'(DSS_BRK_CUR_MAX)));
    wire logic [15:0] stop_dur_lim  = dss_clamp(i_cfg.stop_brake_duration, DSS_BRK_TIME_MAX);
    wire logic [15:0] start_dur_lim = dss_clamp(i_cfg.start_brake_duration, DSS_BRK_TIME_MAX);
    // Settings are writable only while the sequencer rests in IDLE
    wire logic        stopped       = (state_reg == DSS_ST_IDLE);

    // Settings change only while stopped, so a stop in flight keeps its method.
    // A write outside IDLE is dropped, not queued; the host must repeat it.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_reg <= '{DSS_METHOD_RST, DSS_BRK_FREQ_RST, DSS_BRK_CUR_RST,
                         DSS_START_BRK_RST, DSS_STOP_BRK_RST};
        end else if (i_cfg_write && stopped) begin
            cfg_reg <= '{i_cfg.stop_method_select, brk_freq_lim, brk_cur_lim, start_dur_lim, stop_dur_lim};
        end
    end

    // Effective braking start point never below the minimum output frequency
    wire logic [15:0] brk_start = (cfg_reg.brake_start_frequency < i_min_output_frequency) ?
                                  i_min_output_frequency : cfg_reg.brake_start_frequency;

    // Only the DC braking stop follows the baseblock with injection
    wire logic meth_dcbrake = (cfg_reg.stop_method_select == DSS_STOP_DCBRAKE);

    // Ramp step per tick: fmax per decel_time ticks, kept as a fraction in ramp_acc.
    // The remainder carries from tick to tick, so rounding never builds up and the
    // full ramp takes the deceleration time however the division falls.
    wire logic [31:0] ramp_sum  = ramp_acc_reg + 32'(i_max_output_frequency);
    wire logic [31:0] dec_den   = (i_decel_time_first == '0) ? 32'h1 : 32'(i_decel_time_first);
    wire logic [31:0] ramp_step = ramp_sum / dec_den;
    wire logic [31:0] ramp_rem  = ramp_sum - ramp_step * dec_den;
    wire logic [15:0] dc_time   = dss_scale(cfg_reg.stop_brake_duration, stop_freq_reg, i_max_output_frequency);
    wire logic [15:0] lock_time = dss_scale(i_decel_time_first, freq_reg, i_max_output_frequency);
    wire logic [15:0] tmr_dec   = (tick && timer_reg != '0) ? timer_reg - 16'h1 : timer_reg;
    wire logic [15:0] ramp_freq = (ramp_step >= 32'(freq_reg)) ? 16'h0 : freq_reg - ramp_step[15:0];

    // Sequencer. RUN follows the target; the method latched in the settings picks
    // the way back to IDLE:
    //   ramp     RUN -> RAMP -> STOP_DC when a stop time is set -> IDLE
    //   coast    RUN -> BASEBLK -> IDLE
    //   DC stop  RUN -> BASEBLK -> STOP_DC unless the scaled time is zero -> IDLE
    //   lockout  RUN -> LOCKOUT -> IDLE
    // Start braking, when set, sits between IDLE and RUN.
    // A timer loaded with N runs N ticks, and the state leaves on the edge after
    // it reaches zero.
    always_comb begin
        // Hold by default; the timer counts down on every tick
        state_next    = state_reg;
        timer_next    = tmr_dec;
        freq_next     = freq_reg;
        ramp_acc_next = ramp_acc_reg;
        case (state_reg)
            DSS_ST_IDLE: begin
                freq_next = '0;
                if (i_run) begin
                    if (cfg_reg.start_brake_duration != '0) begin
                        state_next = DSS_ST_START_DC;
                        timer_next = cfg_reg.start_brake_duration;
                    end else begin
                        state_next = DSS_ST_RUN;
                    end
                end
            end
            DSS_ST_START_DC: begin
                // Dropping run during start braking abandons the start
                if (!i_run) begin
                    state_next = DSS_ST_IDLE;
                end else if (timer_reg == '0) begin
                    state_next = DSS_ST_RUN;
                end
            end
            DSS_ST_RUN: begin
                freq_next = i_target_frequency;
                if (!i_run) begin
                    // Freeze the stop-instant frequency for the scaled times
                    freq_next = freq_reg;
                    ramp_acc_next = '0;
                    case (cfg_reg.stop_method_select)
                        DSS_STOP_RAMP: state_next = DSS_ST_RAMP;
                        DSS_STOP_COAST: begin
                            state_next = DSS_ST_BASEBLK;
                            timer_next = i_min_output_off_interval;
                        end
                        DSS_STOP_DCBRAKE: begin
                            state_next = DSS_ST_BASEBLK;
                            timer_next = i_min_output_off_interval;
                        end
                        DSS_STOP_COAST_TMR: begin
                            state_next = DSS_ST_LOCKOUT;
                            timer_next = lock_time;
                        end
                        default: state_next = DSS_ST_RAMP;
                    endcase
                end
            end
            DSS_ST_RAMP: begin
                // Run coming back during the ramp resumes driving at the target
                if (i_run) begin
                    state_next = DSS_ST_RUN;
                end else if (freq_reg < brk_start || freq_reg == '0) begin
                    freq_next = '0;
                    if (cfg_reg.stop_brake_duration != '0) begin
                        state_next = DSS_ST_STOP_DC;
                        timer_next = cfg_reg.stop_brake_duration;
                    end else begin
                        state_next = DSS_ST_IDLE;
                    end
                end else if (tick) begin
                    freq_next     = ramp_freq;
                    ramp_acc_next = ramp_rem;
                end
            end
            DSS_ST_BASEBLK: begin
                // Output stays off until the baseblock timer runs out
                if (timer_reg == '0) begin
                    if (meth_dcbrake && dc_time != '0) begin
                        state_next = DSS_ST_STOP_DC;
                        timer_next = dc_time;
                    end else begin
                        state_next = DSS_ST_IDLE;
                    end
                    freq_next = '0;
                end
            end
            DSS_ST_STOP_DC: begin
                // Injection holds the frequency at zero for the whole span
                freq_next = '0;
                if (timer_reg == '0) begin
                    state_next = DSS_ST_IDLE;
                end
            end
            DSS_ST_LOCKOUT: begin
                // Run requests stay ignored until the lockout timer expires
                if (timer_reg == '0) begin
                    state_next = DSS_ST_IDLE;
                    freq_next  = '0;
                end
            end
            default: state_next = DSS_ST_IDLE;
        endcase
    end

    // Baseblock and lockout drop the generator and ignore run; flags are built from the
    // next state so every output lines up with o_state
    wire logic out_on_next = (state_next == DSS_ST_RUN) || (state_next == DSS_ST_RAMP) ||
                             (state_next == DSS_ST_START_DC) || (state_next == DSS_ST_STOP_DC);
    wire logic inj_next    = (state_next == DSS_ST_START_DC) || (state_next == DSS_ST_STOP_DC);
    wire logic ign_next    = i_run && ((state_next == DSS_ST_BASEBLK) ||
                                       (state_next == DSS_ST_LOCKOUT));
    // Percent to permille of rated current; 100 maps to 1000, the rated current
    wire logic [9:0] cur_pm = 10'(cfg_reg.brake_current_percent) * DSS_PCT_TO_PM;

    // Sequencer state, timer and ramp registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg    <= DSS_ST_IDLE;
            timer_reg    <= '0;
            freq_reg     <= '0;
            ramp_acc_reg <= '0;
        end else begin
            state_reg    <= state_next;
            timer_reg    <= timer_next;
            freq_reg     <= freq_next;
            ramp_acc_reg <= ramp_acc_next;
        end
    end

    // Track the running frequency; on leaving RUN it holds the stop-instant value
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stop_freq_reg <= '0;
        end else if (state_reg == DSS_ST_RUN) begin
            stop_freq_reg <= freq_reg;
        end
    end

    // Power stage flags follow the next state so they line up with o_state
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_ignored_reg <= 1'b0;
            inject_reg      <= 1'b0;
            current_reg     <= '0;
            o_output_enable <= 1'b0;
        end else begin
            run_ignored_reg <= ign_next;
            inject_reg      <= inj_next;
            current_reg     <= inj_next ? cur_pm : 10'h000;
            o_output_enable <= out_on_next;
        end
    end

    // Frequency output is zero whenever the stage is off or injecting
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_output_frequency <= '0;
        end else if (out_on_next && !inj_next) begin
            o_output_frequency <= freq_next;
        end else begin
            o_output_frequency <= '0;
        end
    end

    // Remaining outputs are the registers themselves
    assign o_dc_inject           = inject_reg;
    assign o_dc_current_permille = current_reg;
    assign o_run_ignored         = run_ignored_reg;
    assign o_state               = state_reg;
    assign o_cfg_active          = cfg_reg;

endmodule
`default_nettype wire

// File: sim/dss_motor_model.sv
`timescale 1ns/100ps
`default_nettype none
// Motor behind the power stage: follows a driven frequency, drifts down while coasting
module dss_motor_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [15:0] i_frequency,
    input  wire logic        i_drive,
    input  wire logic        i_brake,
    output logic [15:0]      o_speed
);
    // Injection stops the rotor much faster than friction alone, so a braked stop is visible
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            o_speed <= 16'h0000;
        else if (i_brake)
            o_speed <= (o_speed > 16'h0010) ? o_speed - 16'h0010 : 16'h0000;
        else if (i_drive && i_frequency != 16'h0000)
            o_speed <= i_frequency;
        else if (o_speed != 16'h0000)
            o_speed <= o_speed - 16'h0001; // Slow drift while coasting
    end
endmodule
`default_nettype wire

// File: sim/dss_drive_stop_sequencer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dss_stop_chk
    import dss_pkg::*;
#(
    parameter int TICK_CYC = DSS_TICK_CYC
) (
    input wire logic                  i_clk,
    input wire logic                  i_rst_n,
    input wire logic                  i_run,
    input wire dss_cfg_t              i_cfg,
    input wire logic                  i_cfg_write,
    input wire logic [DSS_FREQ_W-1:0] i_target_frequency,
    input wire logic [DSS_FREQ_W-1:0] i_min_output_frequency,
    input wire logic [DSS_FREQ_W-1:0] i_max_output_frequency,
    input wire logic [DSS_TIME_W-1:0] i_decel_time_first,
    input wire logic [DSS_TIME_W-1:0] i_min_output_off_interval,
    input wire logic [DSS_FREQ_W-1:0] o_output_frequency,
    input wire logic                  o_output_enable,
    input wire logic                  o_dc_inject,
    input wire logic [9:0]            o_dc_current_permille,
    input wire logic                  o_run_ignored,
    input wire logic [2:0]            o_state,
    input wire dss_cfg_t              o_cfg_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Stop request from RUN lands in the state that the active method selects
    AST_M0_RAMP: assert property (o_state == DSS_ST_RUN && !i_run && o_cfg_active.stop_method_select == 2'h0
        |=> o_state inside {DSS_ST_RAMP, DSS_ST_STOP_DC, DSS_ST_IDLE}) else $error("ramp stop not entered");
    AST_M12_BB: assert property (o_state == DSS_ST_RUN && !i_run && o_cfg_active.stop_method_select inside {2'h1, 2'h2}
        |=> o_state == DSS_ST_BASEBLK) else $error("baseblock not entered");
    AST_M3_LOCK: assert property (o_state == DSS_ST_RUN && !i_run && o_cfg_active.stop_method_select == 2'h3
        |=> o_state == DSS_ST_LOCKOUT) else $error("lockout not entered");
    // Ramp may only fall while the stop is in progress
    AST_RAMP_FALL: assert property (o_state == DSS_ST_RAMP && $past(o_state) == DSS_ST_RAMP
        |-> o_output_frequency <= $past(o_output_frequency)) else $error("ramp frequency rose");
    AST_NO_RESTART: assert property (o_state inside {DSS_ST_BASEBLK, DSS_ST_LOCKOUT}
        |=> !(o_state inside {DSS_ST_RUN, DSS_ST_START_DC})) else $error("run accepted in lockout");
    AST_COAST_OFF: assert property (o_state inside {DSS_ST_BASEBLK, DSS_ST_LOCKOUT}
        |-> !o_output_enable && !o_dc_inject) else $error("output live while coasting");
    AST_INJ_CUR: assert property (o_dc_inject
        |-> o_dc_current_permille == 10'(o_cfg_active.brake_current_percent) * 10'h00a) else $error("bad current");
    AST_INJ_IDLE: assert property (!o_dc_inject |-> o_dc_current_permille == 10'h000) else $error("current leak");
    AST_INJ_STATE: assert property (o_dc_inject
        |-> o_state inside {DSS_ST_START_DC, DSS_ST_STOP_DC} && o_output_frequency == 16'h0000) else $error("bad inject");
    AST_CFG_HOLD: assert property (o_state != DSS_ST_IDLE |=> $stable(o_cfg_active)) else $error("cfg changed");
endmodule
bind dss_drive_stop_sequencer dss_stop_chk #(.TICK_CYC(TICK_CYC)) dss_stop_chk_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_run(i_run), .i_cfg(i_cfg), .i_cfg_write(i_cfg_write),
    .i_target_frequency(i_target_frequency), .i_min_output_frequency(i_min_output_frequency),
    .i_max_output_frequency(i_max_output_frequency), .i_decel_time_first(i_decel_time_first),
    .i_min_output_off_interval(i_min_output_off_interval), .o_output_frequency(o_output_frequency),
    .o_output_enable(o_output_enable), .o_dc_inject(o_dc_inject), .o_dc_current_permille(o_dc_current_permille),
    .o_run_ignored(o_run_ignored), .o_state(o_state), .o_cfg_active(o_cfg_active));
`default_nettype wire

// File: sim/dss_drive_stop_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dss_drive_stop_sequencer_tb;
    import dss_pkg::*;
    localparam int TK = 4; // Short tick keeps the run brief
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_run = 1'b0;
    logic        i_cfg_write = 1'b0;
    dss_cfg_t    i_cfg = '0;
    logic [15:0] fset[5] = '{16'h012c, 16'h0050, 16'h0258, 16'h0014, 16'h000c}; // 30Hz 8Hz 60Hz 20t 12t
    logic [15:0] o_output_frequency;
    logic [15:0] speed;
    logic [9:0]  o_dc_current_permille;
    logic [2:0]  o_state;
    logic        o_output_enable;
    logic        o_dc_inject;
    logic        o_run_ignored;
    dss_cfg_t    o_cfg_active;
    int          failures = 0;
    int          total_checks = 0;
    int          cnt[8];
    int          inj;
    int          ign;
    logic [15:0] last_ramp;
    logic [9:0]  cur_seen;
    always #5 i_clk = ~i_clk;
    dss_drive_stop_sequencer #(.TICK_CYC(TK)) dss_drive_stop_sequencer_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_run(i_run), .i_cfg(i_cfg), .i_cfg_write(i_cfg_write), .i_target_frequency(fset[0]),
        .i_min_output_frequency(fset[1]), .i_max_output_frequency(fset[2]), .i_decel_time_first(fset[3]),
        .i_min_output_off_interval(fset[4]), .o_output_frequency(o_output_frequency),
        .o_output_enable(o_output_enable), .o_dc_inject(o_dc_inject), .o_dc_current_permille(o_dc_current_permille),
        .o_run_ignored(o_run_ignored), .o_state(o_state), .o_cfg_active(o_cfg_active));
    dss_motor_model dss_motor_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_frequency(o_output_frequency),
        .i_drive(o_output_enable), .i_brake(o_dc_inject), .o_speed(speed));
    // Sample settled outputs half a cycle after the launching edge
    always @(negedge i_clk) begin
        if (i_rst_n) begin
            cnt[o_state] += 1;
            inj += int'(o_dc_inject === 1'b1);
            ign += int'(o_run_ignored === 1'b1);
            if (o_state === DSS_ST_RAMP) last_ramp = o_output_frequency;
            if (o_dc_inject === 1'b1) cur_seen = o_dc_current_permille;
        end
    end
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, got);
        end
    endtask
    // Tick phase is free running, so a timed span may be one tick short or long
    task automatic chk_tk(input string name, input int n, input int got);
        total_checks++;
        if (got < (n - 1) * TK || got > (n + 1) * TK + 2) begin
            failures++;
            $display("unexpected %s: expected %0d ticks seen %0d cycles", name, n, got);
        end
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (int n = 0; o_state !== s; n++) begin
            if (n > 3000) begin
                chk("state wait", 64'(s), 64'(o_state));
                return;
            end
            @(negedge i_clk);
        end
    endtask
    task automatic cfg_wr(input dss_cfg_t c);
        @(negedge i_clk) i_cfg = c;
        i_cfg_write = 1'b1;
        @(negedge i_clk) i_cfg_write = 1'b0;
    endtask
    // Run, then stop; with hold the run command stays high through any lockout
    task automatic run_stop(input dss_cfg_t c, input bit hold);
        cfg_wr(c);
        cnt = '{default: 0};
        inj = 0;
        ign = 0;
        last_ramp = 16'hffff;
        cur_seen = 10'h000;
        i_run = 1'b1;
        wait_st(DSS_ST_RUN);
        repeat (3) @(negedge i_clk);
        chk("run enable", 64'h1, 64'(o_output_enable));
        chk("run frequency", 64'h12c, 64'(o_output_frequency));
        i_run = 1'b0;
        repeat (2) @(negedge i_clk);
        i_run = hold;
        wait_st(DSS_ST_IDLE);
        i_run = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #300us;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        chk("reset cfg", 64'({2'h0, 16'h0005, 7'h32, 16'h0000, 16'h0032}), 64'(o_cfg_active));
        chk("reset enable", 64'h0, 64'(o_output_enable));
        $display("test reset done");
        run_stop('{2'h0, 16'h0005, 7'h28, 16'h0005, 16'h0006}, 1'b0);
        chk_tk("start dc", 5, cnt[DSS_ST_START_DC]);
        chk_tk("stop dc", 6, cnt[DSS_ST_STOP_DC]);
        chk("ramp floor", 64'h1, 64'(last_ramp >= 16'h0032 && last_ramp < 16'h006e));
        chk_tk("ramp time", 8, cnt[DSS_ST_RAMP]);
        chk("brake current", 64'h190, 64'(cur_seen));
        run_stop('{2'h0, 16'h0005, 7'h28, 16'h0000, 16'h0000}, 1'b0);
        chk("no inject", 64'h0, 64'(inj));
        $display("test ramp done");
        run_stop('{2'h1, 16'h0005, 7'h32, 16'h0000, 16'h0032}, 1'b1);
        chk_tk("coast baseblock", 12, cnt[DSS_ST_BASEBLK]);
        chk("run ignored", 64'h1, 64'(ign > 0));
        chk("coast no dc", 64'h0, 64'(inj));
        run_stop('{2'h2, 16'h0005, 7'h32, 16'h0000, 16'h0014}, 1'b0);
        chk_tk("dc baseblock", 12, cnt[DSS_ST_BASEBLK]);
        chk_tk("dc scaled", 10, cnt[DSS_ST_STOP_DC]);
        chk("motor stopped", 64'h0, 64'(speed));
        run_stop('{2'h3, 16'h0005, 7'h32, 16'h0000, 16'h0032}, 1'b1);
        chk_tk("lockout", 10, cnt[DSS_ST_LOCKOUT]);
        chk("lock ignored", 64'h1, 64'(ign > 0));
        $display("test methods done");
        cfg_wr('{2'h0, 16'h00ff, 7'h7f, 16'hffff, 16'hffff});
        chk("clamp", 64'({2'h0, 16'h0064, 7'h64, 16'h03e8, 16'h03e8}), 64'(o_cfg_active));
        cfg_wr('{2'h0, 16'h0005, 7'h32, 16'h0000, 16'h0004});
        i_run = 1'b1;
        wait_st(DSS_ST_RUN);
        cfg_wr('{2'h3, 16'h0005, 7'h32, 16'h0000, 16'h0004});
        chk("refused write", 64'h0, 64'(o_cfg_active.stop_method_select));
        i_run = 1'b0;
        wait_st(DSS_ST_IDLE);
        $display("test settings done");
        print_verdict();
    end
endmodule
`default_nettype wire
